// ### design/scdsyn_pkg.sv
// Purpose: constants for the sample clock divider and sync block
// Assumes: clk_sys is the input clock at 25 MHz
// Notes:   register offset, field positions and timing counts live here
package scdsyn_pkg;
  // register map
  localparam logic [8:0] ADDR_CLOCK_SYNC = 9'h100;
  localparam int         BIT_SYNC_EN     = 1;
  localparam int         BIT_SYNC_FIRST  = 2;
  localparam logic [7:0] RST_CLOCK_SYNC  = 8'h00;
  localparam int         DIV_LSB         = 4;
  localparam logic [2:0] RST_DIV_CODE    = 3'h0;
  // clock rate and stabilizer timing
  localparam int         CLK_HZ          = 25_000_000;
  localparam int         DCS_MIN_HZ      = 20_000_000;
  localparam int         RELOCK_MIN_NS   = 1500;
  localparam int         RELOCK_MAX_NS   = 5000;
  localparam int         CLK_PERIOD_NS   = 1_000_000_000 / CLK_HZ;
  // longest wait is honoured so a user never trusts an unlocked loop
  localparam int         RELOCK_CYC      = (RELOCK_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] RELOCK_CYC_W    = 8'(RELOCK_CYC);
  localparam logic       DCS_RATE_OK     = (CLK_HZ >= DCS_MIN_HZ);
endpackage

// ### design/scdsyn_top.sv
// Purpose: sample clock divider with sync realignment and duty stabilizer
// Assumes: sync_in arrives from outside and is synchronised here
// Notes:   register port is a simple byte write/read port at the documented address
// Summary of operation
// [R1] divide input clock by 1 to 8
// [R2] two bits choose every-sync or first-sync realign
// [R3] accepted sync resets divider counter
// [R4] sync input passes a two-flop synchronizer
// [R5] sender aligns sync to input clock
// [R6] stabilizer gives 50% high time, rising kept; code holds high (N-1)/2 of N cycles at odd ratios
// [R7] software enables stabilizer for odd ratios
// [R8] stabilizer inactive below about 20 MHz
// [R9] stabilizer relock wait 1.5 to 5 us
// [R10] sample strobe on internal clock rising edge; at ratio 1 the code holds the strobe high every clock
// [R11] strap pin selects stabilizer default
// [R12] one internal rising edge per N clocks; at ratio 1 sample_clk toggles each clock, one rising edge per 2 clocks
// [R13] first-sync mode ignores later syncs until write
module scdsyn_top
(
  // clock and reset
  input  wire  logic       clk_sys,
  input  wire  logic       rst,
  // register port
  input  wire  logic [8:0] reg_addr,
  input  wire  logic       reg_wr,
  input  wire  logic [7:0] reg_wdata,
  output logic       [7:0] reg_rdata,
  // pins
  input  wire  logic       sync_in,
  input  wire  logic       serial_data_or_stabilizer_select_pin,
  input  wire  logic       freq_change,
  // internal clock and stabilizer lock outputs
  output logic             sample_clk,
  output logic             sample_strobe,
  output logic             dcs_locked
);
  typedef enum logic [1:0] {S_ARMED = 2'b00, S_DONE = 2'b01} scdsyn_sync_t;

  logic [7:0]   ctrl_q;
  logic [2:0]   div_code_q;
  logic         duty_cycle_stabilizer_q;
  logic         strap_taken_q;
  logic [1:0]   sync_ff_q;
  logic         sync_prev_q;
  logic         sync_edge;
  logic         sync_accept;
  scdsyn_sync_t sync_state_q;
  logic [2:0]   cnt_q;
  logic [2:0]   cnt_d;
  logic [2:0]   half;
  logic         clk_hi_q;
  logic [7:0]   relock_q;
  logic         wr_hit;
  logic [1:0]   strap_ff_q;
  logic         sync_en;
  logic         sync_first_only;
  logic         sync_armed;
  logic         sync_done_set;
  logic         ratio_one;
  logic         dcs_active;
  logic         clk_hi_d;

  assign wr_hit = reg_wr && (reg_addr == scdsyn_pkg::ADDR_CLOCK_SYNC);

  // mode bits decoded once so every user agrees on them
  assign sync_en         = ctrl_q[scdsyn_pkg::BIT_SYNC_EN];
  assign sync_first_only = ctrl_q[scdsyn_pkg::BIT_SYNC_FIRST];
  assign sync_armed      = (sync_state_q == S_ARMED);
  assign ratio_one       = (div_code_q == 3'h0);
  // retime only when asked, locked and fast enough
  assign dcs_active      = duty_cycle_stabilizer_q && dcs_locked && scdsyn_pkg::DCS_RATE_OK; // R8

  // strap is a pin, so synchronise before use
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      strap_ff_q <= 2'h0;
    else
      strap_ff_q <= {strap_ff_q[0], serial_data_or_stabilizer_select_pin};
  end

  // register: bits 1,2 sync mode, bits 6:4 ratio minus one, bit 7 stabilizer
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ctrl_q     <= scdsyn_pkg::RST_CLOCK_SYNC;
      div_code_q <= scdsyn_pkg::RST_DIV_CODE;
    end
    else if (wr_hit)
    begin
      ctrl_q     <= reg_wdata; // R2
      div_code_q <= reg_wdata[scdsyn_pkg::DIV_LSB +: 3]; // R1
    end
  end

  // strap only rules until software first writes the register
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      strap_taken_q <= 1'b0;
    else if (wr_hit)
      strap_taken_q <= 1'b1;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      duty_cycle_stabilizer_q <= 1'b0;
    else if (wr_hit)
      duty_cycle_stabilizer_q <= reg_wdata[7];
    else if (!strap_taken_q)
      duty_cycle_stabilizer_q <= strap_ff_q[1]; // R11
  end

  // read back: stored fields, bit 0 shows a first-only sync was taken
  always_comb
  begin
    reg_rdata = 8'h00;
    if (reg_addr == scdsyn_pkg::ADDR_CLOCK_SYNC)
    begin
      reg_rdata[7]   = duty_cycle_stabilizer_q;
      reg_rdata[6:4] = div_code_q;
      reg_rdata[3]   = ctrl_q[3];
      reg_rdata[2:1] = ctrl_q[2:1];
      reg_rdata[0]   = (sync_state_q == S_DONE);
    end
  end

  // sync synchronizer, sender keeps it aligned to the input clock
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      sync_ff_q   <= 2'h0;
      sync_prev_q <= 1'b0;
    end
    else
    begin
      sync_ff_q   <= {sync_ff_q[0], sync_in}; // R4
      sync_prev_q <= sync_ff_q[1];
    end
  end

  assign sync_edge   = sync_ff_q[1] && !sync_prev_q;
  assign sync_accept = sync_edge && sync_en && (!sync_first_only || sync_armed); // R2 R13
  // a write landing with an accepted sync wins and leaves the mode rearmed
  assign sync_done_set = sync_accept && sync_first_only && !wr_hit;

  // first-sync tracking, a write rearms
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      sync_state_q <= S_ARMED;
    else
    begin
      case (sync_state_q)
        S_ARMED:
          if (sync_done_set)
            sync_state_q <= S_DONE; // R13
        S_DONE:
          if (wr_hit)
            sync_state_q <= S_ARMED;
        default:
          sync_state_q <= S_ARMED;
      endcase
    end
  end

  // divider counter
  always_comb
  begin
    cnt_d = cnt_q + 3'h1;
    if (sync_accept || cnt_q >= div_code_q)
      cnt_d = 3'h0; // R3 R12
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      cnt_q <= 3'h0;
    else
      cnt_q <= cnt_d; // R1 R12
  end

  // high time: half period rounded down with stabilizer, else one input cycle
  // for odd ratios without stabilizer duty is uneven, hence advice to enable it
  assign half = 3'((4'(div_code_q) + 4'h1) >> 1); // R6
  always_comb
  begin
    clk_hi_d = (cnt_d == 3'h0);
    if (ratio_one)
      clk_hi_d = ~clk_hi_q;
    else if (dcs_active)
      clk_hi_d = (cnt_d < half); // R6 R8
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      clk_hi_q <= 1'b0;
    else
      clk_hi_q <= clk_hi_d;
  end

  assign sample_clk = clk_hi_q;

  // strobe marks the sampling edge, one input cycle wide except at ratio 1, where it stays high every clock
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      sample_strobe <= 1'b0;
    else
      sample_strobe <= (cnt_d == 3'h0); // R10
  end

  // relock timer after clock frequency change
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      relock_q <= scdsyn_pkg::RELOCK_CYC_W;
    else if (freq_change)
      relock_q <= scdsyn_pkg::RELOCK_CYC_W; // R9
    else if (relock_q != 8'h00)
      relock_q <= relock_q - 8'h01;
  end

  assign dcs_locked = (relock_q == 8'h00);
endmodule

// ### testbench/scdsyn_properties.sv
// Purpose: port checks for scdsyn_top
// Assumes: bench parks reg_addr at 9'h100
// Notes:   bound below
module scdsyn_properties
(
  // clock, reset
  input wire logic       clk_sys,
  input wire logic       rst,
  // registers
  input wire logic [8:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // status
  input wire logic       freq_change,
  input wire logic       sample_strobe,
  input wire logic       dcs_locked
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  a_unmapped_zero: assert property (reg_addr != 9'h100 |-> reg_rdata == 8'h00) else $error("bad read");
  a_write_seen: assert property (reg_wr && reg_addr == 9'h100 ##1 reg_addr == 9'h100
    |-> reg_rdata[7:1] == $past(reg_wdata[7:1])) else $error("write lost");
  a_ratio_one: assert property ((reg_addr == 9'h100 && reg_rdata[6:4] == 3'h0) [*3]
    |-> sample_strobe) else $error("ratio one");
  a_strobe_due: assert property (1'b1 |-> ##[0:15] sample_strobe) else $error("no strobe");
  a_relock_low: assert property (freq_change |=> !dcs_locked [*8]) else $error("early lock");
  a_relock_due: assert property (freq_change |-> ##[1:130] (dcs_locked || freq_change)) else $error("no lock");
  // two cycles in, so the clocked reset branch has surely run
  a_reset_reg: assert property (disable iff (1'b0) rst ##1 rst && reg_addr == 9'h100
    |-> reg_rdata[6:0] == 7'h00) else $error("reset value");
  a_reset_quiet: assert property (disable iff (1'b0) rst ##1 rst
    |-> !sample_strobe && !dcs_locked) else $error("busy in reset");
endmodule
bind scdsyn_top scdsyn_properties u_scdsyn_properties (.*);

// ### testbench/scdsyn_sync_src.sv
// Purpose: system sync driver model
// Assumes: go is a one-cycle request
// Notes:   launched off clk_sys so parts align
module scdsyn_sync_src
(
  // request
  input wire logic clk_sys,
  input wire logic go,
  // pin
  output logic     sync_in
);
  timeunit 1ns;
  timeprecision 1ns;
  initial sync_in = 1'b0;
  always @(posedge clk_sys) sync_in <= go;
endmodule

// ### testbench/test_sample_clock_divider_sync.sv
// Purpose: bench for scdsyn_top
// Assumes: sync cases run at ratio 8
// Notes:   m and used model the register
module test_sample_clock_divider_sync;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk_sys = 1'b0, rst = 1'b1, reg_wr = 1'b0, freq_change = 1'b0, go = 1'b0, used = 1'b0, acc;
  logic       serial_data_or_stabilizer_select_pin = 1'b0, sync_in, sample_strobe, dcs_locked, sample_clk;
  logic [8:0] reg_addr = 9'h100;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, m;
  int         n_errors = 0, compares = 0, n;
  scdsyn_sync_src u_scdsyn_sync_src (.*);
  scdsyn_top u_scdsyn_top (.*);
  initial forever #20 clk_sys = ~clk_sys;
  task automatic chk(input logic [7:0] g, e);
    compares++;
    if (g !== e) $display("MISMATCH %0t got %h exp %h", $time, g, e);
    if (g !== e) n_errors++;
  endtask
  task automatic test_done();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    if (a == 9'h100) {m, used} = {d, 1'b0};
    @(posedge clk_sys);
    {reg_addr, reg_wr} <= {9'h100, 1'b0};
    #1 chk(reg_rdata, {m[7:1], used});
  endtask
  task automatic await(ref logic s);
    n = 0;
    do @(posedge clk_sys) #1 n++; while (s !== 1'b1 && n < 300);
    if (n == 300) n_errors++;
    if (n == 300) test_done();
  endtask
  // high cycles over one period of 2*hi input cycles, counted from a strobe
  task automatic duty(input logic [7:0] d, input int hi);
    wr(9'h100, d);
    await(sample_strobe);
    n = (sample_clk === 1'b1);
    repeat (2 * hi - 1) @(posedge clk_sys) #1 n += (sample_clk === 1'b1);
    chk(8'(n), 8'(hi));
  endtask
  initial
  begin
    void'($urandom(44));
    serial_data_or_stabilizer_select_pin = 1'($urandom);
    m = {serial_data_or_stabilizer_select_pin, 7'h00};
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    #1 chk(reg_rdata, scdsyn_pkg::RST_CLOCK_SYNC);
    // strap needs two synchroniser edges and one load edge
    repeat (3) @(posedge clk_sys);
    #1 chk(reg_rdata, m);
    for (int r = 1; r <= 8; r++)
    begin
      wr(9'h100, {1'($urandom), 3'(r - 1), 1'($urandom), 3'h0});
      // first gap may straddle the ratio change
      await(sample_strobe);
      await(sample_strobe);
      chk(8'(n), 8'(r));
    end
    // sync one cycle after a strobe: realign gives 3, free run gives 6
    // i = 8 writes first-only mode again, which must rearm it
    for (int i = 0; i < 10; i++)
    begin
      if (i % 2 == 0) wr(9'h100, 8'hF0 | 8'(i < 8 ? i : 6));
      await(sample_strobe);
      @(posedge clk_sys) go <= 1'b1;
      @(posedge clk_sys) go <= 1'b0;
      acc = m[1] && !(m[2] && used);
      used = used | (acc && m[2]);
      await(sample_strobe);
      chk(8'(n), acc ? 8'h03 : 8'h06);
      chk(reg_rdata, {m[7:1], used});
    end
    @(posedge clk_sys) freq_change <= 1'b1;
    @(posedge clk_sys) freq_change <= 1'b0;
    #1 chk(8'(dcs_locked), 8'h00);
    await(dcs_locked);
    chk(8'(n >= 38 && n <= 126), 8'h01);
    duty(8'hF0, 4);
    duty(8'hB0, 2);
    duty(8'h10, 1);
    wr(9'h0FF, 8'($urandom));
    @(posedge clk_sys) reg_addr <= 9'h0FF;
    #1 chk(reg_rdata, 8'h00);
    test_done();
  end
endmodule
